// ### verilog/chc_pkg.sv
package chc_pkg;

    // register offsets
    localparam logic [7:0] ADDR_TERM_TIMER   = 8'h05;
    localparam logic [7:0] ADDR_INPUT_BOOST  = 8'h06;
    localparam logic [7:0] ADDR_DETECT_SWCH  = 8'h07;

    // reset values
    localparam logic [7:0] RST_TERM_TIMER    = 8'h9f;
    localparam logic [7:0] RST_INPUT_BOOST   = 8'he6;
    localparam logic [7:0] RST_DETECT_SWCH   = 8'h4c;

    // bits reloaded on watchdog expiry
    localparam logic [7:0] WDM_TERM_TIMER    = 8'hff;
    localparam logic [7:0] WDM_INPUT_BOOST   = 8'h00;
    localparam logic [7:0] WDM_DETECT_SWCH   = 8'hd4;

    // field positions, termination_timer_thermal_control
    localparam int TERM_EN_BIT    = 7;
    localparam int WDT_LSB        = 4;
    localparam int TIMER_EN_BIT   = 3;
    localparam int TIMER_LONG_BIT = 2;
    localparam int THERMAL_BIT    = 1;
    localparam int COOL_BIT       = 0;
    // input_boost_voltage_limits
    localparam int OVP_LSB        = 6;
    localparam int BOOST_LSB      = 4;
    localparam int VLIM_LSB       = 0;
    // detection_and_battery_switch_control
    localparam int DETECT_BIT     = 7;
    localparam int HALF_BIT       = 6;
    localparam int SW_DIS_BIT     = 5;
    localparam int WARM_BIT       = 4;
    localparam int SW_DLY_BIT     = 3;
    localparam int SW_RST_BIT     = 2;
    localparam int TRACK_LSB      = 0;

    // timing
    localparam int CLOCK_PERIOD_NS   = 4;
    localparam int TICK_PERIOD_NS    = 1000000;
    localparam int CYCLES_PER_TICK   = TICK_PERIOD_NS / CLOCK_PERIOD_NS;
    localparam int TICKS_PER_SECOND  = 1000;
    localparam int WDT_BASE_S        = 40;
    localparam int SHIP_DELAY_MS     = 12500;
    localparam int SAFETY_SHORT_H    = 5;
    localparam int SAFETY_LONG_H     = 10;
    localparam int SECONDS_PER_HOUR  = 3600;
    localparam int MS_PER_SECOND     = 1000;

    // analog settings
    localparam logic [7:0]  THERM_LOW_C    = 8'h50;
    localparam logic [7:0]  THERM_HIGH_C   = 8'h78;
    localparam logic [6:0]  COOL_PCT_HALF  = 7'h32;
    localparam logic [6:0]  COOL_PCT_FIFTH = 7'h14;
    localparam logic [15:0] WARM_CAP_MV    = 16'h1004;
    localparam logic [15:0] VLIM_BASE_MV   = 16'h0f3c;
    localparam logic [15:0] VLIM_STEP_MV   = 16'h0064;

    typedef struct packed {
        logic supply_present;
        logic detect_done;
        logic charging;
        logic power_limited;
        logic cool_band;
        logic thermal_reg;
    } chc_sense_type;

    typedef struct packed {
        logic        term_enable;
        logic [7:0]  wdt_seconds;
        logic [7:0]  thermal_c;
        logic [6:0]  cool_pct;
        logic [15:0] ovp_mv;
        logic [15:0] boost_mv;
        logic [15:0] input_limit_mv;
        logic [15:0] warm_voltage_mv;
        logic        switch_reset_enable;
    } chc_cfg_type;

    function automatic logic [15:0] ovp_mv(input logic [1:0] code);
        case (code)
            2'h0:    ovp_mv = 16'h157c;
            2'h1:    ovp_mv = 16'h1964;
            2'h2:    ovp_mv = 16'h2904;
            default: ovp_mv = 16'h36b0;
        endcase
    endfunction

    function automatic logic [15:0] boost_mv(input logic [1:0] code);
        case (code)
            2'h0:    boost_mv = 16'h12f2;
            2'h1:    boost_mv = 16'h1388;
            2'h2:    boost_mv = 16'h141e;
            default: boost_mv = 16'h14b4;
        endcase
    endfunction

    function automatic logic [15:0] track_mv(input logic [1:0] code);
        case (code)
            2'h1:    track_mv = 16'h00c8;
            2'h2:    track_mv = 16'h00fa;
            2'h3:    track_mv = 16'h012c;
            default: track_mv = 16'h0000;
        endcase
    endfunction

endpackage

// ### verilog/chc_tick.sv
`timescale 1ns/1ns
module chc_tick
    import chc_pkg::*;
#(
    parameter int CYCLES = CYCLES_PER_TICK
) (
    input  wire logic clock,
    input  wire logic reset_n,
    output logic      tick
);
    if (CYCLES < 2) begin : g_bad_cycles
        $error("chc_tick: CYCLES must be at least 2");
    end

    typedef struct packed {
        logic [31:0] count;
        logic        tick;
    } chc_tick_state_type;

    chc_tick_state_type st_r;
    chc_tick_state_type st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (st_r.count == 32'(CYCLES - 1)) begin
            st_nxt.count = 32'h0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.count = st_r.count + 32'h1;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;
endmodule

// ### verilog/chc_regs.sv
`timescale 1ns/1ns
module chc_regs
    import chc_pkg::*;
#(
    parameter int CYCLES_PER_MS = CYCLES_PER_TICK,
    parameter int TICKS_PER_SEC = TICKS_PER_SECOND
) (
    input  wire logic          clock,
    input  wire logic          reset_n,
    input  wire logic [7:0]    reg_addr,
    input  wire logic [7:0]    reg_wdata,
    input  wire logic          reg_write,
    output logic      [7:0]    reg_rdata,
    input  wire logic          register_reset,
    input  wire logic          watchdog_kick,
    input  wire chc_sense_type sense,
    input  wire logic [15:0]   battery_mv,
    input  wire logic [15:0]   programmed_charge_voltage_mv,
    output chc_cfg_type        cfg,
    output logic               current_detect_request,
    output logic               battery_switch_off,
    output logic               safety_timer_expired,
    output logic               watchdog_expired
);
    // counters are sized for at most 1000 ticks per second
    if (TICKS_PER_SEC < 1 || TICKS_PER_SEC > 1000) begin : g_bad_tps
        $error("chc_regs: TICKS_PER_SEC must be 1..1000");
    end

    localparam int WDT_TICKS  = WDT_BASE_S * TICKS_PER_SEC;
    localparam int SHIP_RAW   = SHIP_DELAY_MS * TICKS_PER_SEC / MS_PER_SECOND;
    localparam int SHIP_TICKS = (SHIP_RAW < 1) ? 1 : SHIP_RAW;
    // safety timer counts half ticks so the slow rate is a plain add of one
    localparam logic [27:0] SAFE_SHORT_LIM =
        28'(SAFETY_SHORT_H * SECONDS_PER_HOUR * TICKS_PER_SEC * 2);
    localparam logic [27:0] SAFE_LONG_LIM =
        28'(SAFETY_LONG_H * SECONDS_PER_HOUR * TICKS_PER_SEC * 2);

    typedef struct packed {
        logic [7:0]    term_timer;
        logic [7:0]    input_boost;
        logic [7:0]    detect_swch;
        chc_sense_type sync1;
        chc_sense_type sync2;
        logic [17:0]   wdt_cnt;
        logic          wdt_expired;
        logic [13:0]   ship_cnt;
        logic          switch_off;
        logic [27:0]   safe_cnt;
        logic          safe_expired;
        logic [7:0]    rdata;
        chc_cfg_type   cfg;
        logic          detect_req;
    } chc_state_type;

    chc_state_type st_r;
    chc_state_type st_nxt;
    logic          tick;

    chc_tick #(
        .CYCLES (CYCLES_PER_MS)
    ) u_tick (
        .clock   (clock),
        .reset_n (reset_n),
        .tick    (tick)
    );

    function automatic logic [17:0] wdt_limit(input logic [1:0] code);
        case (code)
            2'h1:    wdt_limit = 18'(WDT_TICKS);
            2'h2:    wdt_limit = 18'(WDT_TICKS * 2);
            2'h3:    wdt_limit = 18'(WDT_TICKS * 4);
            default: wdt_limit = 18'h0;
        endcase
    endfunction

    function automatic logic [7:0] wdt_seconds(input logic [1:0] code);
        case (code)
            2'h1:    wdt_seconds = 8'(WDT_BASE_S);
            2'h2:    wdt_seconds = 8'(WDT_BASE_S * 2);
            2'h3:    wdt_seconds = 8'(WDT_BASE_S * 4);
            default: wdt_seconds = 8'h0;
        endcase
    endfunction

    logic [1:0]  wdt_code;
    logic [17:0] wdt_lim;
    logic        wdt_fire;
    logic        slow;
    logic [27:0] safe_lim;
    logic [27:0] safe_step;
    logic        timer_run;
    logic [15:0] vlim_prog;
    logic [15:0] vlim_track;

    always_comb begin
        st_nxt = st_r;
        wdt_code = st_r.term_timer[WDT_LSB +: 2];
        wdt_lim = wdt_limit(wdt_code);
        wdt_fire = 1'b0;
        slow = 1'b0;
        safe_lim = SAFE_LONG_LIM;
        safe_step = 28'h2;
        timer_run = 1'b0;
        vlim_prog = 16'h0;
        vlim_track = 16'h0;

        st_nxt.sync1 = sense;
        st_nxt.sync2 = st_r.sync1;

        // host writes; any write also refreshes the watchdog
        if (reg_write) begin
            case (reg_addr)
                ADDR_TERM_TIMER:  st_nxt.term_timer = reg_wdata;
                ADDR_INPUT_BOOST: st_nxt.input_boost = reg_wdata;
                ADDR_DETECT_SWCH: st_nxt.detect_swch = reg_wdata;
                default: ;
            endcase
        end

        // detection done clears the bit unless the host sets it this cycle
        if (st_r.sync2.detect_done && st_r.detect_swch[DETECT_BIT] &&
            !(reg_write && reg_addr == ADDR_DETECT_SWCH && reg_wdata[DETECT_BIT])) begin
            st_nxt.detect_swch[DETECT_BIT] = 1'b0;
        end

        // watchdog: 00 disables, else 40/80/160 s
        if (wdt_code == 2'h0 || watchdog_kick || reg_write) begin
            st_nxt.wdt_cnt = 18'h0;
        end else if (tick) begin
            if (st_r.wdt_cnt + 18'h1 >= wdt_lim) begin
                wdt_fire = 1'b1;
                st_nxt.wdt_cnt = 18'h0;
            end else begin
                st_nxt.wdt_cnt = st_r.wdt_cnt + 18'h1;
            end
        end
        if (wdt_fire) begin
            st_nxt.wdt_expired = 1'b1;
            // limits, boost, switch disable, delay and tracking survive expiry
            st_nxt.term_timer = (st_nxt.term_timer & ~WDM_TERM_TIMER) |
                                (RST_TERM_TIMER & WDM_TERM_TIMER);
            st_nxt.input_boost = (st_nxt.input_boost & ~WDM_INPUT_BOOST) |
                                 (RST_INPUT_BOOST & WDM_INPUT_BOOST);
            st_nxt.detect_swch = (st_nxt.detect_swch & ~WDM_DETECT_SWCH) |
                                 (RST_DETECT_SWCH & WDM_DETECT_SWCH);
        end else if (watchdog_kick || reg_write) begin
            st_nxt.wdt_expired = 1'b0;
        end

        // safety timer over precharge and fast charge
        timer_run = st_r.term_timer[TIMER_EN_BIT] && st_r.sync2.charging;
        safe_lim = st_r.term_timer[TIMER_LONG_BIT] ? SAFE_LONG_LIM
                                                   : SAFE_SHORT_LIM;
        slow = st_r.detect_swch[HALF_BIT] &&
               (st_r.sync2.power_limited || st_r.sync2.cool_band ||
                st_r.sync2.thermal_reg);
        safe_step = slow ? 28'h1 : 28'h2;
        if (!timer_run) begin
            st_nxt.safe_cnt = 28'h0;
            st_nxt.safe_expired = 1'b0;
        end else if (tick && !st_r.safe_expired) begin
            if (st_r.safe_cnt + safe_step >= safe_lim) begin
                st_nxt.safe_expired = 1'b1;
            end
            st_nxt.safe_cnt = st_r.safe_cnt + safe_step;
        end

        // battery switch turn-off, immediate or after the shipping delay
        if (!st_r.detect_swch[SW_DIS_BIT]) begin
            st_nxt.ship_cnt = 14'h0;
            st_nxt.switch_off = 1'b0;
        end else if (!st_r.detect_swch[SW_DLY_BIT]) begin
            st_nxt.switch_off = 1'b1;
        end else if (tick && !st_r.switch_off) begin
            if (st_r.ship_cnt + 14'h1 >= 14'(SHIP_TICKS)) begin
                st_nxt.switch_off = 1'b1;
            end
            st_nxt.ship_cnt = st_r.ship_cnt + 14'h1;
        end

        // register reset beats every other update this cycle
        if (register_reset) begin
            st_nxt.term_timer = RST_TERM_TIMER;
            st_nxt.input_boost = RST_INPUT_BOOST;
            st_nxt.detect_swch = RST_DETECT_SWCH;
            st_nxt.safe_cnt = 28'h0;
            st_nxt.safe_expired = 1'b0;
            st_nxt.wdt_cnt = 18'h0;
            st_nxt.wdt_expired = 1'b0;
            st_nxt.ship_cnt = 14'h0;
            st_nxt.switch_off = 1'b0;
        end

        // read data, unmapped offsets read zero
        case (reg_addr)
            ADDR_TERM_TIMER:  st_nxt.rdata = st_r.term_timer;
            ADDR_INPUT_BOOST: st_nxt.rdata = st_r.input_boost;
            ADDR_DETECT_SWCH: st_nxt.rdata = st_r.detect_swch;
            default:          st_nxt.rdata = 8'h00;
        endcase

        // decoded settings for the analog loops
        st_nxt.cfg.term_enable = st_r.term_timer[TERM_EN_BIT];
        st_nxt.cfg.wdt_seconds = wdt_seconds(wdt_code);
        st_nxt.cfg.thermal_c = st_r.term_timer[THERMAL_BIT] ? THERM_HIGH_C
                                                            : THERM_LOW_C;
        st_nxt.cfg.cool_pct = st_r.term_timer[COOL_BIT] ? COOL_PCT_FIFTH
                                                        : COOL_PCT_HALF;
        st_nxt.cfg.ovp_mv = ovp_mv(st_r.input_boost[OVP_LSB +: 2]);
        st_nxt.cfg.boost_mv = boost_mv(st_r.input_boost[BOOST_LSB +: 2]);
        vlim_prog = VLIM_BASE_MV +
                    16'(st_r.input_boost[VLIM_LSB +: 4]) * VLIM_STEP_MV;
        // tracking disabled leaves the programmed limit alone
        vlim_track = (st_r.detect_swch[TRACK_LSB +: 2] == 2'h0) ? 16'h0 :
                     battery_mv + track_mv(st_r.detect_swch[TRACK_LSB +: 2]);
        st_nxt.cfg.input_limit_mv = (vlim_track > vlim_prog) ? vlim_track
                                                             : vlim_prog;
        if (st_r.detect_swch[WARM_BIT]) begin
            st_nxt.cfg.warm_voltage_mv = programmed_charge_voltage_mv;
        end else begin
            st_nxt.cfg.warm_voltage_mv =
                (programmed_charge_voltage_mv < WARM_CAP_MV) ?
                programmed_charge_voltage_mv : WARM_CAP_MV;
        end
        st_nxt.cfg.switch_reset_enable = st_r.detect_swch[SW_RST_BIT];
        st_nxt.detect_req = st_r.detect_swch[DETECT_BIT] &&
                            st_r.sync2.supply_present;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
            st_r.term_timer <= RST_TERM_TIMER;
            st_r.input_boost <= RST_INPUT_BOOST;
            st_r.detect_swch <= RST_DETECT_SWCH;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign cfg = st_r.cfg;
    assign current_detect_request = st_r.detect_req;
    assign battery_switch_off = st_r.switch_off;
    assign safety_timer_expired = st_r.safe_expired;
    assign watchdog_expired = st_r.wdt_expired;
endmodule

// ### testbench/chc_regs_chk.sv
`timescale 1ns/1ns
module chc_regs_chk
    import chc_pkg::*;
#(
    parameter int CYCLES_PER_MS = CYCLES_PER_TICK,
    parameter int TICKS_PER_SEC = TICKS_PER_SECOND
) (
    input wire logic          clock,
    input wire logic          reset_n,
    input wire logic [7:0]    reg_addr,
    input wire logic [7:0]    reg_wdata,
    input wire logic          reg_write,
    input wire logic [7:0]    reg_rdata,
    input wire logic          register_reset,
    input wire logic          watchdog_kick,
    input wire chc_sense_type sense,
    input wire logic [15:0]   programmed_charge_voltage_mv,
    input wire chc_cfg_type   cfg,
    input wire logic          current_detect_request,
    input wire logic          battery_switch_off,
    input wire logic          safety_timer_expired,
    input wire logic          watchdog_expired
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    sequence sw_wr_s;
        reg_write && reg_addr == ADDR_DETECT_SWCH && !register_reset;
    endsequence
    sequence quiet3_s;
        (!reg_write && !register_reset)[*3];
    endsequence
    write_read_a: assert property (
        (reg_write && reg_addr == ADDR_INPUT_BOOST && !register_reset)
        ##1 (reg_addr == ADDR_INPUT_BOOST && !reg_write && !register_reset)
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("limits register read back differs from write");
    ship_now_a: assert property (
        sw_wr_s ##0 (reg_wdata[SW_DIS_BIT] && !reg_wdata[SW_DLY_BIT])
        |-> ##[1:3] battery_switch_off)
        else $error("switch not off promptly");
    ship_clear_a: assert property (
        sw_wr_s ##0 !reg_wdata[SW_DIS_BIT] |-> ##[1:3] !battery_switch_off)
        else $error("switch still off after disable cleared");
    reset_dflt_a: assert property (
        register_reset ##1 quiet3_s |-> cfg.term_enable && cfg.switch_reset_enable
        && cfg.thermal_c == THERM_HIGH_C && cfg.boost_mv == 16'h141e)
        else $error("defaults not restored by register reset");
    wdt_clear_a: assert property (
        (watchdog_kick || reg_write || register_reset) |-> ##[1:2] !watchdog_expired)
        else $error("watchdog flag not cleared");
    detect_clear_a: assert property (
        (sense.detect_done && !reg_write)[*6] |-> !current_detect_request)
        else $error("detection request outlives completion");
    wdt_reload_a: assert property (
        $rose(watchdog_expired) ##0 (reg_addr == ADDR_TERM_TIMER && !reg_write)[*2]
        |-> reg_rdata == RST_TERM_TIMER)
        else $error("control register not reloaded on expiry");
    warm_cap_a: assert property (
        reset_n && $past(reset_n) |-> cfg.warm_voltage_mv <= programmed_charge_voltage_mv)
        else $error("warm voltage above programmed voltage");
    // two synchroniser stages plus the timer register itself
    safe_stop_a: assert property (
        (!sense.charging)[*3] |=> !safety_timer_expired)
        else $error("safety timer expired without charging");
    safe_rst_a: assert property (
        register_reset |=> !safety_timer_expired)
        else $error("safety timer not restarted by register reset");
endmodule
bind chc_regs chc_regs_chk #(.CYCLES_PER_MS(CYCLES_PER_MS), .TICKS_PER_SEC(TICKS_PER_SEC)) i_chk (
    .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_rdata(reg_rdata), .register_reset(register_reset),
    .watchdog_kick(watchdog_kick), .sense(sense),
    .programmed_charge_voltage_mv(programmed_charge_voltage_mv), .cfg(cfg),
    .current_detect_request(current_detect_request),
    .battery_switch_off(battery_switch_off), .safety_timer_expired(safety_timer_expired),
    .watchdog_expired(watchdog_expired));

// ### testbench/chc_host.sv
`timescale 1ns/1ns
module chc_host (
    input  wire logic       clock,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_write,
    input  wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
    end
    // every write also restarts the watchdog, so settings hold while traffic runs
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        reg_wdata <= ~d;  // stale data must not pass for valid
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        @(posedge clock);
        @(negedge clock);
        d = reg_rdata;
    endtask
endmodule

// ### testbench/chc_regs_test.sv
`timescale 1ns/1ns
module chc_regs_test;
    import chc_pkg::*;
    logic          clock;
    logic          reset_n;
    logic [7:0]    reg_addr;
    logic [7:0]    reg_wdata;
    logic          reg_write;
    logic [7:0]    reg_rdata;
    logic          register_reset;
    logic          watchdog_kick;
    chc_sense_type sense;
    logic [15:0]   battery_mv;
    logic [15:0]   prog_mv;
    chc_cfg_type   cfg;
    logic          detect_req;
    logic          switch_off;
    logic          wdt_exp;
    logic          safe_exp;
    logic [7:0]    rv;
    logic [1:0]    cc;
    int            miscompares;
    int            check_count;
    logic [15:0]   ovp_t[4]   = '{16'h157c, 16'h1964, 16'h2904, 16'h36b0};
    logic [15:0]   boost_t[4] = '{16'h12f2, 16'h1388, 16'h141e, 16'h14b4};
    logic [15:0]   wdt_t[4]   = '{16'h0000, 16'h0028, 16'h0050, 16'h00a0};
    chc_host i_host (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_rdata(reg_rdata));
    // short ms tick and one tick per second keep the watchdog and shipping counts within a few hundred cycles
    chc_regs #(.CYCLES_PER_MS(4), .TICKS_PER_SEC(1)) i_dut (.clock(clock), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_rdata(reg_rdata), .register_reset(register_reset), .watchdog_kick(watchdog_kick),
        .sense(sense), .battery_mv(battery_mv), .programmed_charge_voltage_mv(prog_mv),
        .cfg(cfg), .current_detect_request(detect_req), .battery_switch_off(switch_off),
        .safety_timer_expired(safe_exp), .watchdog_expired(wdt_exp));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        i_host.rd(a, rv);
        chk("reg_rdata", {8'h00, e}, {8'h00, rv});
    endtask
    task automatic st;
        repeat (3) @(posedge clock);
        @(negedge clock);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        tally_and_finish;
    end
    initial begin
        reset_n        = 1'b0;
        register_reset = 1'b0;
        watchdog_kick  = 1'b0;
        sense          = '0;
        battery_mv     = 16'h1130;
        prog_mv        = 16'h1068;
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        i_host.wr(8'h04, 8'hff);
        rchk(8'h08, 8'h00);
        rchk(ADDR_TERM_TIMER, 8'h9f);
        rchk(ADDR_INPUT_BOOST, 8'he6);
        rchk(ADDR_DETECT_SWCH, 8'h4c);
        chk("term", 16'h0001, {15'h0, cfg.term_enable});
        chk("wdt", 16'h0028, {8'h00, cfg.wdt_seconds});
        chk("cool", 16'h0014, {9'h0, cfg.cool_pct});
        chk("ovp", 16'h36b0, cfg.ovp_mv);
        chk("limit", 16'h1194, cfg.input_limit_mv);
        chk("warm", 16'h1004, cfg.warm_voltage_mv);
        chk("swrst", 16'h0001, {15'h0, cfg.switch_reset_enable});
        $display("test defaults done");
        for (int c = 0; c < 4; c++) begin
            cc = c[1:0];
            i_host.wr(ADDR_TERM_TIMER, {cc[1], 1'b0, cc, 2'b11, cc[0], cc[1]});
            st;
            chk("term", {15'h0, cc[1]}, {15'h0, cfg.term_enable});
            chk("wdt", wdt_t[c], {8'h00, cfg.wdt_seconds});
            chk("thermal", cc[0] ? 16'h0078 : 16'h0050, {8'h00, cfg.thermal_c});
            chk("cool", cc[1] ? 16'h0014 : 16'h0032, {9'h0, cfg.cool_pct});
            i_host.wr(ADDR_INPUT_BOOST, {cc, cc, cc, cc});
            st;
            chk("ovp", ovp_t[c], cfg.ovp_mv);
            chk("boost", boost_t[c], cfg.boost_mv);
            chk("limit", 16'h0f3c + 16'h01f4 * c[15:0], cfg.input_limit_mv);
        end
        i_host.wr(ADDR_TERM_TIMER, 8'h8f);
        i_host.wr(ADDR_INPUT_BOOST, 8'he6);
        i_host.wr(ADDR_DETECT_SWCH, 8'h4d);
        st;
        chk("limit", 16'h11f8, cfg.input_limit_mv);
        @(posedge clock);
        battery_mv <= 16'h0fa0;
        i_host.wr(ADDR_DETECT_SWCH, 8'h5f);
        st;
        chk("limit", 16'h1194, cfg.input_limit_mv);
        chk("warm", 16'h1068, cfg.warm_voltage_mv);
        $display("test fields done");
        i_host.wr(ADDR_DETECT_SWCH, 8'h20);
        st;
        chk("switch_off", 16'h0001, {15'h0, switch_off});
        // an already open switch stays open, so close it before the delayed case
        i_host.wr(ADDR_DETECT_SWCH, 8'h08);
        st;
        chk("switch_off", 16'h0000, {15'h0, switch_off});
        i_host.wr(ADDR_DETECT_SWCH, 8'h28);
        repeat (40) @(posedge clock);
        @(negedge clock);
        chk("switch_off", 16'h0000, {15'h0, switch_off});
        for (int i = 0; i < 12 && switch_off !== 1'b1; i++) @(negedge clock);
        @(negedge clock);
        chk("switch_off", 16'h0001, {15'h0, switch_off});
        @(posedge clock);
        sense.supply_present <= 1'b1;
        i_host.wr(ADDR_DETECT_SWCH, 8'hcc);
        st;
        chk("switch_off", 16'h0000, {15'h0, switch_off});
        chk("detect", 16'h0001, {15'h0, detect_req});
        @(posedge clock);
        sense.detect_done <= 1'b1;
        repeat (6) @(posedge clock);
        rchk(ADDR_DETECT_SWCH, 8'h4c);
        chk("detect", 16'h0000, {15'h0, detect_req});
        sense <= '0;
        $display("test switch and detection done");
        i_host.wr(ADDR_TERM_TIMER, 8'h18);
        i_host.wr(ADDR_INPUT_BOOST, 8'h00);
        i_host.wr(ADDR_DETECT_SWCH, 8'h10);
        rchk(ADDR_TERM_TIMER, 8'h18);
        repeat (148) @(posedge clock);
        @(negedge clock);
        chk("wdt_exp", 16'h0000, {15'h0, wdt_exp});
        for (int i = 0; i < 12 && wdt_exp !== 1'b1; i++) @(negedge clock);
        @(negedge clock);
        chk("wdt_exp", 16'h0001, {15'h0, wdt_exp});
        rchk(ADDR_TERM_TIMER, 8'h9f);
        rchk(ADDR_INPUT_BOOST, 8'h00);
        rchk(ADDR_DETECT_SWCH, 8'h44);
        @(posedge clock);
        watchdog_kick <= 1'b1;
        @(posedge clock);
        watchdog_kick <= 1'b0;
        st;
        chk("wdt_exp", 16'h0000, {15'h0, wdt_exp});
        $display("test watchdog done");
        @(posedge clock);
        sense.charging <= 1'b1;
        i_host.wr(ADDR_TERM_TIMER, 8'h8f);
        @(posedge clock);
        register_reset <= 1'b1;
        @(posedge clock);
        register_reset <= 1'b0;
        rchk(ADDR_TERM_TIMER, 8'h9f);
        rchk(ADDR_INPUT_BOOST, 8'he6);
        chk("safe_exp", 16'h0000, {15'h0, safe_exp});
        $display("test register reset done");
        tally_and_finish;
    end
endmodule
